/* common/tcmu_pkg.sv */
// Package with register map, field layout, modes and carriers of the compare match unit.
package tcmu_pkg;

	// ---------------------------------------------------------------
	// Register offsets (byte addresses, one word each)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_VALUE  = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MASK   = 8'h0C;
	localparam logic [7:0] ADDR_ALTSEL = 8'h10;
	localparam logic [7:0] ADDR_STATE  = 8'h14;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int          MODE_LSB        = 0;
	localparam int          MODE_W          = 4;
	localparam int          STAT_MATCH_BIT  = 0;
	localparam int          STAT_TRIG_BIT   = 1;
	localparam int          STAT_W          = 2;
	localparam int          STATE_LATCH_BIT = 0;
	localparam int          STATE_EQ_BIT    = 1;
	localparam int          STATE_PEND_BIT  = 2;
	localparam logic [3:0]  CTRL_RST        = 4'h0;
	localparam logic [15:0] VALUE_RST       = 16'hFFFF;
	localparam logic [1:0]  STAT_RST        = 2'h0;
	localparam logic [1:0]  MASK_RST        = 2'h0;
	localparam logic        ALTSEL_RST      = 1'b0;

	// ---------------------------------------------------------------
	// Compare mode codes
	// ---------------------------------------------------------------
	localparam logic [3:0] MODE_OFF    = 4'h0;
	localparam logic [3:0] MODE_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_SET    = 4'h8;
	localparam logic [3:0] MODE_CLEAR  = 4'h9;
	localparam logic [3:0] MODE_SWINT  = 4'hA;
	localparam logic [3:0] MODE_TRIG   = 4'hB;

	typedef enum logic [2:0] {
		TCMU_ACT_NONE,
		TCMU_ACT_TOGGLE,
		TCMU_ACT_SET,
		TCMU_ACT_CLEAR,
		TCMU_ACT_SWINT,
		TCMU_ACT_TRIG
	} tcmu_action_e;

	// Timer side signals travel together.
	typedef struct packed {
		logic [15:0] count;
		logic        tick;
	} tcmu_timer_s;

	typedef struct packed {
		logic pin_drive;
		logic pin_level;
		logic alt_sel;
	} tcmu_pin_s;

endpackage : tcmu_pkg

/* hdl/tcmu_top.sv */
// Compare match unit with a classic Wishbone register slave.
`timescale 1ns/10ps

module tcmu_top #(
	parameter int CNT_W = 16
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	input  wire logic                 wb_we_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	output logic                      wb_ack_o,
	output logic                      wb_err_o,
	input  wire tcmu_pkg::tcmu_timer_s timer_in,
	input  wire logic                 adc_enabled,
	output logic                      timer_clear,
	output logic                      adc_start,
	output tcmu_pkg::tcmu_pin_s       pin_out,
	output logic                      irq
);

	// The compare and register datapaths are built for a sixteen-bit count only.
	if (CNT_W != 16) begin : g_cnt_w_check
		$error("tcmu_top: CNT_W must be 16");
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [3:0]             ctrl_ff;
	logic [15:0]            value_ff;
	logic [1:0]             status_ff;
	logic [1:0]             mask_ff;
	logic                   altsel_ff;
	logic                   latch_ff;
	logic                   eq_prev_ff;
	logic                   pend_ff;
	logic                   ack_ff;
	logic [31:0]            rdata_ff;
	logic                   err_ff;
	logic                   equal;
	logic                   match_evt;
	logic                   trig_evt;
	logic                   bus_req;
	logic                   wr_en;
	logic                   ctrl_wr_zero;
	logic                   addr_ok;
	logic [31:0]            nxt_rdata;
	tcmu_pkg::tcmu_action_e act;

	// ---------------------------------------------------------------
	// Match detection
	// ---------------------------------------------------------------
	assign equal     = (timer_in.count == value_ff);
	assign match_evt = equal && !eq_prev_ff && (act != tcmu_pkg::TCMU_ACT_NONE);
	assign trig_evt  = match_evt && (act == tcmu_pkg::TCMU_ACT_TRIG);

	always_comb begin
		unique case (ctrl_ff)
			tcmu_pkg::MODE_TOGGLE: act = tcmu_pkg::TCMU_ACT_TOGGLE;
			tcmu_pkg::MODE_SET:    act = tcmu_pkg::TCMU_ACT_SET;
			tcmu_pkg::MODE_CLEAR:  act = tcmu_pkg::TCMU_ACT_CLEAR;
			tcmu_pkg::MODE_SWINT:  act = tcmu_pkg::TCMU_ACT_SWINT;
			tcmu_pkg::MODE_TRIG:   act = tcmu_pkg::TCMU_ACT_TRIG;
			default:               act = tcmu_pkg::TCMU_ACT_NONE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			eq_prev_ff <= 1'b0;
		end else begin
			eq_prev_ff <= equal;
		end
	end

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	// A request is taken once; the cycle that shows ack or err never starts a second one.
	assign bus_req      = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
	assign wr_en        = bus_req && wb_we_i && addr_ok;
	assign ctrl_wr_zero = wr_en && (wb_adr_i == tcmu_pkg::ADDR_CTRL) && wb_sel_i[0] && (wb_dat_i[3:0] == 4'h0);

	always_comb begin
		addr_ok   = 1'b1;
		nxt_rdata = 32'h0000_0000;
		unique case (wb_adr_i)
			tcmu_pkg::ADDR_CTRL:   nxt_rdata[3:0]  = ctrl_ff;
			tcmu_pkg::ADDR_VALUE:  nxt_rdata[15:0] = value_ff;
			tcmu_pkg::ADDR_STATUS: nxt_rdata[1:0]  = status_ff;
			tcmu_pkg::ADDR_MASK:   nxt_rdata[1:0]  = mask_ff;
			tcmu_pkg::ADDR_ALTSEL: nxt_rdata[0]    = altsel_ff;
			tcmu_pkg::ADDR_STATE:  nxt_rdata[2:0]  = {pend_ff, equal, latch_ff};
			default:               addr_ok         = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack_ff   <= 1'b0;
			err_ff   <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff   <= bus_req && addr_ok;
			err_ff   <= bus_req && !addr_ok;
			rdata_ff <= (bus_req && !wb_we_i && addr_ok) ? nxt_rdata : 32'h0000_0000;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_err_o = err_ff;
	assign wb_dat_o = rdata_ff;

	// ---------------------------------------------------------------
	// Control and configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_ff <= tcmu_pkg::CTRL_RST;
		end else if (wr_en && wb_adr_i == tcmu_pkg::ADDR_CTRL && wb_sel_i[0]) begin
			ctrl_ff <= wb_dat_i[3:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			value_ff <= tcmu_pkg::VALUE_RST;
		end else if (wr_en && wb_adr_i == tcmu_pkg::ADDR_VALUE) begin
			if (wb_sel_i[0]) begin
				value_ff[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				value_ff[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mask_ff   <= tcmu_pkg::MASK_RST;
			altsel_ff <= tcmu_pkg::ALTSEL_RST;
		end else if (wr_en && wb_sel_i[0]) begin
			if (wb_adr_i == tcmu_pkg::ADDR_MASK) begin
				mask_ff <= wb_dat_i[1:0];
			end
			if (wb_adr_i == tcmu_pkg::ADDR_ALTSEL) begin
				altsel_ff <= wb_dat_i[0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Compare output latch
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			latch_ff <= 1'b0;
		end else if (ctrl_wr_zero) begin
			latch_ff <= 1'b0;
		end else if (match_evt) begin
			unique case (act)
				tcmu_pkg::TCMU_ACT_TOGGLE: latch_ff <= !latch_ff;
				tcmu_pkg::TCMU_ACT_SET:    latch_ff <= 1'b1;
				tcmu_pkg::TCMU_ACT_CLEAR:  latch_ff <= 1'b0;
				default:                   latch_ff <= latch_ff;
			endcase
		end
	end

	assign pin_out = '{
		pin_drive: (act == tcmu_pkg::TCMU_ACT_TOGGLE) || (act == tcmu_pkg::TCMU_ACT_SET)
			|| (act == tcmu_pkg::TCMU_ACT_CLEAR),
		pin_level: latch_ff,
		alt_sel:   altsel_ff
	};

	// ---------------------------------------------------------------
	// Conversion trigger and timer reset
	// ---------------------------------------------------------------
	assign adc_start = trig_evt && adc_enabled;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pend_ff <= 1'b0;
		end else if (trig_evt) begin
			pend_ff <= 1'b1;
		end else if (pend_ff && (!equal || act != tcmu_pkg::TCMU_ACT_TRIG)) begin
			pend_ff <= 1'b0;
		end else if (pend_ff && timer_in.tick) begin
			pend_ff <= 1'b0;
		end
	end

	// Clear is applied together with the timer clock tick; no overflow is implied.
	assign timer_clear = pend_ff && equal && (act == tcmu_pkg::TCMU_ACT_TRIG) && timer_in.tick;

	// ---------------------------------------------------------------
	// Interrupt status
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			status_ff <= tcmu_pkg::STAT_RST;
		end else begin
			for (int i = 0; i < tcmu_pkg::STAT_W; i++) begin
				if (wr_en && wb_adr_i == tcmu_pkg::ADDR_STATUS && wb_sel_i[0] && wb_dat_i[i]) begin
					status_ff[i] <= 1'b0;
				end
			end
			if (match_evt) begin
				status_ff[tcmu_pkg::STAT_MATCH_BIT] <= 1'b1;
			end
			if (trig_evt) begin
				status_ff[tcmu_pkg::STAT_TRIG_BIT] <= 1'b1;
			end
		end
	end

	assign irq = |(status_ff & mask_ff);

endmodule : tcmu_top

/* sim/tcmu_timer_model.sv */
// Behavioural shared timer that counts on a prescaled tick.
`timescale 1ns/10ps
module tcmu_timer_model #(
	parameter int DIV = 8
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             timer_clear,
	output tcmu_pkg::tcmu_timer_s timer_out,
	output logic                  ovf_ff
);
	// ----------------------------------------
	// Timer
	// ----------------------------------------
	logic [7:0]  div_ff;
	logic [15:0] cnt_ff;
	assign timer_out = '{count: cnt_ff, tick: (div_ff == 8'(DIV - 1))};
	always_ff @(posedge core_clk) begin
		div_ff <= (rst || timer_out.tick) ? 8'h00 : div_ff + 8'h01;
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_ff <= 16'h0000;
			ovf_ff <= 1'b0;
		end else if (timer_out.tick && timer_clear) begin
			cnt_ff <= 16'h0000;
		end else if (timer_out.tick) begin
			cnt_ff <= cnt_ff + 16'h0001;
			ovf_ff <= ovf_ff | (cnt_ff == 16'hFFFF);
		end
	end
endmodule : tcmu_timer_model

/* sim/tcmu_checker.sv */
// Concurrent checks on the compare match unit ports.
`timescale 1ns/10ps
module tcmu_checker (
	input wire logic                  core_clk,
	input wire logic                  rst,
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_ack_o,
	input wire logic                  wb_err_o,
	input wire tcmu_pkg::tcmu_timer_s timer_in,
	input wire logic                  adc_enabled,
	input wire logic                  timer_clear,
	input wire logic                  adc_start,
	input wire tcmu_pkg::tcmu_pin_s   pin_out,
	input wire logic                  irq
);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	a_bus_answer_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
		else $error("bus request not answered");
	a_trig_single: assert property (adc_start |=> !adc_start) else $error("trigger repeated");
	a_trig_enabled: assert property (adc_start |-> adc_enabled) else $error("trigger while disabled");
	a_trig_no_pin: assert property (adc_start |-> !pin_out.pin_drive) else $error("pin driven in trigger mode");
	a_clear_on_tick: assert property (timer_clear |-> timer_in.tick) else $error("clear off tick");
	a_clear_count_held: assert property (timer_clear |-> $stable(timer_in.count)) else $error("clear lost");
	a_latch_cause: assert property ($changed(pin_out.pin_level) |-> wb_ack_o || $past(timer_in.tick, 2))
		else $error("latch moved without cause");
	c_trig: cover property (adc_start);
	c_clear: cover property (timer_clear);
	c_err: cover property (wb_err_o);
	c_irq: cover property (irq);
endmodule : tcmu_checker
bind tcmu_top tcmu_checker chk_u (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .timer_in(timer_in), .adc_enabled(adc_enabled),
	.timer_clear(timer_clear), .adc_start(adc_start), .pin_out(pin_out), .irq(irq));

/* sim/tcmu_top_tb.sv */
// Self-checking bench for the compare match unit.
`timescale 1ns/10ps
module tcmu_top_tb;
	// ----------------------------------------
	// Bench
	// ----------------------------------------
	logic                  core_clk = 1'b0, rst = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic                  adc_enabled = 1'b0, exp_lat = 1'b0, msk = 1'b0;
	logic                  wb_ack_o, wb_err_o, timer_clear, adc_start, irq, ovf;
	logic [7:0]            wb_adr_i = 8'h00;
	logic [31:0]           wb_dat_i = 32'h00000000, wb_dat_o;
	logic [3:0]            wb_sel_i = 4'h0;
	logic [15:0]           v;
	logic [32:0]           exp_q[$];
	tcmu_pkg::tcmu_timer_s timer_in;
	tcmu_pkg::tcmu_pin_s   pin_out;
	int                    n_errors = 0, samples_checked = 0, seed = 59846, cyc_n = 0, n_adc = 0, n_clr = 0;
	int                    adc_t = 0, gap = 0;
	tcmu_top dut_u (.core_clk(core_clk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
		.wb_err_o(wb_err_o), .timer_in(timer_in), .adc_enabled(adc_enabled), .timer_clear(timer_clear),
		.adc_start(adc_start), .pin_out(pin_out), .irq(irq));
	tcmu_timer_model #(.DIV(8)) tmr_u (.core_clk(core_clk), .rst(rst), .timer_clear(timer_clear),
		.timer_out(timer_in), .ovf_ff(ovf));
	initial forever #2 core_clk = ~core_clk;
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d, input logic [3:0] s = 4'hF);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_adr_i <= a;
		wb_we_i <= we;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do begin
			@(posedge core_clk);
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		bus(a, 1'b0, 32'h00000000);
	endtask : rd
	task automatic go(input logic [3:0] m, input logic rm, input logic [31:0] st);
		int a0, c0, t;
		v = timer_in.count + 16'(3 + $unsigned($random(seed)) % 4);
		bus(tcmu_pkg::ADDR_VALUE, 1'b1, {16'h0000, v});
		bus(tcmu_pkg::ADDR_CTRL, 1'b1, {28'h0000000, m});
		a0 = n_adc;
		c0 = n_clr;
		t = 0;
		while (timer_in.count !== v && t < 400) begin
			@(posedge core_clk);
			t++;
		end
		if (rm) bus(tcmu_pkg::ADDR_VALUE, 1'b1, {16'h0000, v + 16'h0028});
		repeat (12) @(posedge core_clk);
		chk("pin level", 32'(exp_lat), 32'(pin_out.pin_level));
		chk("pin drive", 32'(m inside {4'h2, 4'h8, 4'h9}), 32'(pin_out.pin_drive));
		chk("trigger count", 32'(m == 4'hB && adc_enabled), 32'(n_adc - a0));
		chk("timer clear count", 32'(m == 4'hB && !rm), 32'(n_clr - c0));
		chk("irq", 32'(msk), 32'(irq));
		rd(tcmu_pkg::ADDR_STATUS, {1'b0, st});
		bus(tcmu_pkg::ADDR_STATUS, 1'b1, 32'h00000003);
		repeat (2) @(posedge core_clk);
		chk("irq cleared", 32'h00000000, 32'(irq));
		$display("test mode %h done", m);
	endtask : go
	always @(posedge core_clk) begin
		cyc_n++;
		if (!rst && adc_start === 1'b1) begin
			n_adc++;
			gap = cyc_n - adc_t;
			adc_t = cyc_n;
		end
		if (!rst && timer_clear === 1'b1) n_clr++;
		if (exp_q.size() > 0 && (wb_err_o === 1'b1 || (wb_ack_o === 1'b1 && wb_we_i === 1'b0))) begin
			chk("bus error", 32'(exp_q[0][32]), 32'(wb_err_o));
			chk("read data", exp_q[0][31:0], wb_dat_o);
			void'(exp_q.pop_front());
		end
		if (cyc_n == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		logic [7:0]  adr[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
		logic [32:0] rv[6] = '{33'h0, 33'h0FFFF, 33'h0, 33'h0, 33'h0, 33'h100000000};
		logic [3:0]  md[3] = '{4'h2, 4'h9, 4'h8};
		int          t;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		foreach (adr[i]) rd(adr[i], rv[i]);
		bus(tcmu_pkg::ADDR_VALUE, 1'b1, 32'h00001234, 4'h2);
		rd(tcmu_pkg::ADDR_VALUE, 33'h0000012FF);
		bus(tcmu_pkg::ADDR_ALTSEL, 1'b1, 32'h00000001);
		@(posedge core_clk);
		chk("alt select", 32'h00000001, 32'(pin_out.alt_sel));
		$display("test registers done");
		foreach (md[i]) begin
			exp_lat = (i != 1);
			go(md[i], 1'b0, 32'h00000001);
		end
		bus(tcmu_pkg::ADDR_CTRL, 1'b1, 32'h00000000);
		@(posedge core_clk);
		chk("latch cleared", 32'h00000000, 32'(pin_out.pin_level));
		exp_lat = 1'b0;
		msk = 1'b1;
		bus(tcmu_pkg::ADDR_MASK, 1'b1, 32'h00000001);
		go(4'hA, 1'b0, 32'h00000001);
		adc_enabled <= 1'b1;
		go(4'hB, 1'b0, 32'h00000003);
		t = n_adc;
		while (n_adc == t && cyc_n < 19000) @(posedge core_clk);
		chk("period", 32'((v + 17'h1) * 8), 32'(gap));
		adc_enabled <= 1'b0;
		go(4'hB, 1'b0, 32'h00000003);
		go(4'hB, 1'b1, 32'h00000003);
		chk("overflow flag", 32'h00000000, 32'(ovf));
		tally_and_finish();
	end
endmodule : tcmu_top_tb
